// file: design/toutu_pin_drive.sv
// registered driver of the selected general purpose pin
`default_nettype none
module toutu_pin_drive #(
  parameter int NUM_PINS = 16
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // unit output
  input  wire logic [3:0]          pin_sel,
  input  wire logic                level,
  input  wire logic                drive,
  // pins
  output logic [NUM_PINS-1:0]      gpio_out,
  output logic [NUM_PINS-1:0]      gpio_oe
);
  if (NUM_PINS < 1 || NUM_PINS > 16)
  begin : g_bad_pins
    $error("NUM_PINS must be 1 to 16");
  end

  // one flop pair per pin; unselected pins are released
  for (genvar p = 0; p < NUM_PINS; p++)
  begin : g_pin
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        gpio_out[p] <= 1'b0;
        gpio_oe[p]  <= 1'b0;
      end
      else
      begin
        gpio_out[p] <= (pin_sel == 4'(p)) && level;
        gpio_oe[p]  <= (pin_sel == 4'(p)) && drive;
      end
    end
  end
endmodule // toutu_pin_drive
`default_nettype wire

// file: design/toutu_pkg.sv
// constants, register map and state type of the timed output unit
`default_nettype none
package toutu_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_CFG_ONE    = 12'h000;
  localparam logic [11:0] OFS_PULSE_W    = 12'h004;
  localparam logic [11:0] OFS_CYC_W_LO   = 12'h008;
  localparam logic [11:0] OFS_CYC_W_HI   = 12'h00C;
  localparam logic [11:0] OFS_CYC_CNT    = 12'h010;
  localparam logic [11:0] OFS_BIT_PAT    = 12'h014;
  localparam logic [11:0] OFS_CASC_LO    = 12'h018;
  localparam logic [11:0] OFS_CASC_HI    = 12'h01C;
  localparam logic [11:0] OFS_TGT_NS_LO  = 12'h020;
  localparam logic [11:0] OFS_TGT_NS_HI  = 12'h024;
  localparam logic [11:0] OFS_TGT_SEC_LO = 12'h028;
  localparam logic [11:0] OFS_TGT_SEC_HI = 12'h02C;
  localparam logic [11:0] OFS_UNIT_EN    = 12'h030;
  localparam logic [11:0] OFS_IRQ_EN     = 12'h034;
  localparam logic [11:0] OFS_STATUS     = 12'h038;
  localparam logic [11:0] OFS_EDGE_SEL   = 12'h248;
  // field positions
  localparam int CFG_PIN_LSB   = 0;
  localparam int CFG_PAT_LSB   = 4;
  localparam int CFG_NOTIFY    = 8;
  localparam int CFG_NOW       = 9;
  localparam int CFG_CASCADE   = 10;
  localparam int CFG_TAIL      = 11;
  localparam int EDGE_SEL_BIT  = 7;
  localparam int STS_DONE      = 0;
  localparam int STS_ERR       = 1;
  localparam int STS_ACTIVE    = 2;
  // reset value of every register
  localparam logic [15:0] REG_RESET = 16'h0000;
  // pattern select codes
  localparam logic [2:0] PAT_NEG_PULSE = 3'h2;
  localparam logic [2:0] PAT_POS_PULSE = 3'h3;
  localparam logic [2:0] PAT_PERIODIC  = 3'h5;
  localparam logic [2:0] PAT_SHIFT     = 3'h6;
  // timing, all in nanoseconds
  localparam logic [31:0] CLK_PERIOD_NS   = 32'h0000000A;
  localparam logic [31:0] CASCADE_LEAD_NS = 32'h00000008;
  localparam logic [31:0] NS_PER_SEC      = 32'h3B9ACA00;
  // unit sequencer states
  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_ARMED = 4'h2,
    S_RUN   = 4'h4,
    S_HOLD  = 4'h8
  } toutu_state_t;
endpackage
`default_nettype wire

// file: design/toutu_time_cmp.sv
// target time compare, early compare and cascade target sum
`default_nettype none
module toutu_time_cmp (
  // current precision time
  input  wire logic [31:0] now_sec,
  input  wire logic [31:0] now_ns,
  // working target and cascade interval
  input  wire logic [31:0] tgt_sec,
  input  wire logic [31:0] tgt_ns,
  input  wire logic [31:0] intv_ns,
  // results
  output logic             reached,
  output logic             early,
  output logic [31:0]      sum_sec,
  output logic [31:0]      sum_ns
);
  logic [32:0] ahead_ns;
  logic [31:0] ahead_sec;
  logic [32:0] acc_ns;
  logic [31:0] carry;

  // time 8 ns ahead, carried into seconds
  always_comb
  begin
    ahead_ns  = {1'b0, now_ns} + {1'b0, toutu_pkg::CASCADE_LEAD_NS};
    ahead_sec = now_sec;
    if (ahead_ns >= {1'b0, toutu_pkg::NS_PER_SEC})
    begin
      ahead_ns  = ahead_ns - {1'b0, toutu_pkg::NS_PER_SEC};
      ahead_sec = now_sec + 32'h00000001;
    end
  end

  // equal or later counts, so a late arm still fires
  assign reached = (now_sec > tgt_sec) ||
                   (now_sec == tgt_sec && now_ns >= tgt_ns);
  assign early   = (ahead_sec > tgt_sec) ||
                   (ahead_sec == tgt_sec &&
                    ahead_ns[31:0] >= tgt_ns);

  // interval may span several seconds, at most five carries
  always_comb
  begin
    acc_ns = {1'b0, tgt_ns} + {1'b0, intv_ns};
    carry  = 32'h00000000;
    for (int i = 0; i < 5; i++)
    begin
      if (acc_ns >= {1'b0, toutu_pkg::NS_PER_SEC})
      begin
        acc_ns = acc_ns - {1'b0, toutu_pkg::NS_PER_SEC};
        carry  = carry + 32'h00000001;
      end
    end
  end

  assign sum_ns  = acc_ns[31:0];
  assign sum_sec = tgt_sec + carry;
endmodule // toutu_time_cmp
`default_nettype wire

// file: design/toutu_top.sv
// one timed trigger output unit with its apb register file
`default_nettype none
module toutu_top #(
  parameter int NUM_PINS = 16
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // precision time, same clock domain
  input  wire logic [31:0]         ptp_sec,
  input  wire logic [31:0]         ptp_nsec,
  // pins
  output logic [NUM_PINS-1:0]      gpio_out,
  output logic [NUM_PINS-1:0]      gpio_oe,
  // done or error notification
  output logic                     notify_irq
);
  // registers
  logic [15:0]  cfg_one_ff;
  logic [15:0]  pulse_w_ff;
  logic [15:0]  cyc_w_lo_ff;
  logic [15:0]  cyc_w_hi_ff;
  logic [15:0]  cyc_cnt_ff;
  logic [15:0]  bit_pat_ff;
  logic [15:0]  casc_lo_ff;
  logic [15:0]  casc_hi_ff;
  logic [15:0]  tgt_ns_lo_ff;
  logic [15:0]  tgt_ns_hi_ff;
  logic [15:0]  tgt_sec_lo_ff;
  logic [15:0]  tgt_sec_hi_ff;
  logic [15:0]  edge_sel_ff;
  logic         en_ff;
  logic         ie_ff;
  logic         done_ff;
  logic         err_ff;
  logic         irq_ff;
  logic [31:0]  prdata_ff;
  // unit state
  toutu_pkg::toutu_state_t state_ff;
  logic [31:0]  wsec_ff;
  logic [31:0]  wns_ff;
  logic [31:0]  el_ff;
  logic [15:0]  seq_ff;
  logic         level_ff;
  logic         late_ff;
  logic         late_drv_ff;
  logic         drive_ff;
  // decode and datapath
  logic         wr_acc;
  logic         hit;
  logic [31:0]  rd_val;
  logic [2:0]   pat;
  logic         casc;
  logic         now_req;
  logic [31:0]  period;
  logic [31:0]  hi_ns;
  logic         reached;
  logic         early;
  logic [31:0]  sum_sec;
  logic [31:0]  sum_ns;
  logic         fire;
  logic         bad_cfg;
  logic         fire_lvl;
  logic         idle_lvl;
  logic [31:0]  el_step;
  logic         wrap;
  logic [31:0]  nxt_el;
  logic [15:0]  seq_inc;
  logic [15:0]  nxt_seq;
  logic         finish;
  logic         run_lvl;
  logic         pin_lvl;
  logic         pin_drv;

  function automatic logic [15:0] merge16(logic [15:0] old,
                                          logic [31:0] wd,
                                          logic [3:0]  strb);
    merge16 = {strb[1] ? wd[15:8] : old[15:8],
               strb[0] ? wd[7:0]  : old[7:0]};
  endfunction

  // apb decode; no wait states, so pready is always high
  assign wr_acc  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_ff;

  // read mux and address decode
  always_comb
  begin
    hit    = 1'b1;
    rd_val = 32'h00000000;
    case (paddr)
      toutu_pkg::OFS_CFG_ONE:    rd_val[15:0] = cfg_one_ff;
      toutu_pkg::OFS_PULSE_W:    rd_val[15:0] = pulse_w_ff;
      toutu_pkg::OFS_CYC_W_LO:   rd_val[15:0] = cyc_w_lo_ff;
      toutu_pkg::OFS_CYC_W_HI:   rd_val[15:0] = cyc_w_hi_ff;
      toutu_pkg::OFS_CYC_CNT:    rd_val[15:0] = cyc_cnt_ff;
      toutu_pkg::OFS_BIT_PAT:    rd_val[15:0] = bit_pat_ff;
      toutu_pkg::OFS_CASC_LO:    rd_val[15:0] = casc_lo_ff;
      toutu_pkg::OFS_CASC_HI:    rd_val[15:0] = casc_hi_ff;
      toutu_pkg::OFS_TGT_NS_LO:  rd_val[15:0] = tgt_ns_lo_ff;
      toutu_pkg::OFS_TGT_NS_HI:  rd_val[15:0] = tgt_ns_hi_ff;
      toutu_pkg::OFS_TGT_SEC_LO: rd_val[15:0] = tgt_sec_lo_ff;
      toutu_pkg::OFS_TGT_SEC_HI: rd_val[15:0] = tgt_sec_hi_ff;
      toutu_pkg::OFS_UNIT_EN:    rd_val[0]    = en_ff;
      toutu_pkg::OFS_IRQ_EN:     rd_val[0]    = ie_ff;
      toutu_pkg::OFS_STATUS:
        rd_val[2:0] = {state_ff == toutu_pkg::S_RUN, err_ff, done_ff};
      toutu_pkg::OFS_EDGE_SEL:   rd_val[15:0] = edge_sel_ff;
      default:                   hit          = 1'b0;
    endcase
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata_ff <= rd_val;
  end

  // configuration writes; immediate bit self-clears when taken
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_one_ff    <= toutu_pkg::REG_RESET;
      pulse_w_ff    <= toutu_pkg::REG_RESET;
      cyc_w_lo_ff   <= toutu_pkg::REG_RESET;
      cyc_w_hi_ff   <= toutu_pkg::REG_RESET;
      cyc_cnt_ff    <= toutu_pkg::REG_RESET;
      bit_pat_ff    <= toutu_pkg::REG_RESET;
      casc_lo_ff    <= toutu_pkg::REG_RESET;
      casc_hi_ff    <= toutu_pkg::REG_RESET;
      tgt_ns_lo_ff  <= toutu_pkg::REG_RESET;
      tgt_ns_hi_ff  <= toutu_pkg::REG_RESET;
      tgt_sec_lo_ff <= toutu_pkg::REG_RESET;
      tgt_sec_hi_ff <= toutu_pkg::REG_RESET;
      edge_sel_ff   <= toutu_pkg::REG_RESET;
    end
    else
    begin
      if (fire)
        cfg_one_ff[toutu_pkg::CFG_NOW] <= 1'b0;
      if (wr_acc)
      begin
        case (paddr)
          toutu_pkg::OFS_CFG_ONE:
            cfg_one_ff <= merge16(cfg_one_ff, pwdata, pstrb);
          toutu_pkg::OFS_PULSE_W:
            pulse_w_ff <= merge16(pulse_w_ff, pwdata, pstrb);
          toutu_pkg::OFS_CYC_W_LO:
            cyc_w_lo_ff <= merge16(cyc_w_lo_ff, pwdata, pstrb);
          toutu_pkg::OFS_CYC_W_HI:
            cyc_w_hi_ff <= merge16(cyc_w_hi_ff, pwdata, pstrb);
          toutu_pkg::OFS_CYC_CNT:
            cyc_cnt_ff <= merge16(cyc_cnt_ff, pwdata, pstrb);
          toutu_pkg::OFS_BIT_PAT:
            bit_pat_ff <= merge16(bit_pat_ff, pwdata, pstrb);
          toutu_pkg::OFS_CASC_LO:
            casc_lo_ff <= merge16(casc_lo_ff, pwdata, pstrb);
          toutu_pkg::OFS_CASC_HI:
            casc_hi_ff <= merge16(casc_hi_ff, pwdata, pstrb);
          toutu_pkg::OFS_TGT_NS_LO:
            tgt_ns_lo_ff <= merge16(tgt_ns_lo_ff, pwdata, pstrb);
          toutu_pkg::OFS_TGT_NS_HI:
            tgt_ns_hi_ff <= merge16(tgt_ns_hi_ff, pwdata, pstrb);
          toutu_pkg::OFS_TGT_SEC_LO:
            tgt_sec_lo_ff <= merge16(tgt_sec_lo_ff, pwdata, pstrb);
          toutu_pkg::OFS_TGT_SEC_HI:
            tgt_sec_hi_ff <= merge16(tgt_sec_hi_ff, pwdata, pstrb);
          toutu_pkg::OFS_EDGE_SEL:
            edge_sel_ff <= merge16(edge_sel_ff, pwdata, pstrb);
          default: ;
        endcase
      end
    end
  end

  // unit enable and interrupt enable bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_ff <= 1'b0;
      ie_ff <= 1'b0;
    end
    else if (wr_acc && pstrb[0])
    begin
      if (paddr == toutu_pkg::OFS_UNIT_EN)
        en_ff <= pwdata[0];
      if (paddr == toutu_pkg::OFS_IRQ_EN)
        ie_ff <= pwdata[0];
    end
  end

  // field views
  assign pat     = cfg_one_ff[toutu_pkg::CFG_PAT_LSB +: 3];
  assign casc    = cfg_one_ff[toutu_pkg::CFG_CASCADE];
  assign now_req = cfg_one_ff[toutu_pkg::CFG_NOW];
  assign period  = {cyc_w_hi_ff, cyc_w_lo_ff};
  assign hi_ns   = {13'h0000, pulse_w_ff, 3'h0};

  toutu_time_cmp u_cmp (
    .now_sec (ptp_sec),
    .now_ns  (ptp_nsec),
    .tgt_sec (wsec_ff),
    .tgt_ns  (wns_ff),
    .intv_ns ({casc_hi_ff, casc_lo_ff}),
    .reached (reached),
    .early   (early),
    .sum_sec (sum_sec),
    .sum_ns  (sum_ns)
  );

  // start on target time or at once on the immediate bit
  assign fire = en_ff && state_ff == toutu_pkg::S_ARMED &&
                (reached || now_req);
  // level held before the pulse: opposite of the pulse
  assign idle_lvl = (pat == toutu_pkg::PAT_NEG_PULSE);

  // settings that cannot produce output raise error
  always_comb
  begin
    bad_cfg  = 1'b0;
    fire_lvl = 1'b0;
    case (pat)
      toutu_pkg::PAT_NEG_PULSE:
      begin
        bad_cfg  = (pulse_w_ff == 16'h0000);
        fire_lvl = 1'b0;
      end
      toutu_pkg::PAT_POS_PULSE:
      begin
        bad_cfg  = (pulse_w_ff == 16'h0000);
        fire_lvl = 1'b1;
      end
      toutu_pkg::PAT_PERIODIC:
      begin
        bad_cfg  = (period == 32'h00000000);
        fire_lvl = (hi_ns != 32'h00000000);
      end
      toutu_pkg::PAT_SHIFT:
      begin
        bad_cfg  = (period == 32'h00000000) ||
                   (cyc_cnt_ff == 16'h0000);
        fire_lvl = bit_pat_ff[0];
      end
      default: bad_cfg = 1'b1;
    endcase
  end

  // waveform step: elapsed ns within a period or pulse
  always_comb
  begin
    el_step = el_ff + toutu_pkg::CLK_PERIOD_NS;
    wrap    = (el_step >= period);
    nxt_el  = wrap ? el_step - period : el_step;
    seq_inc = seq_ff + 16'h0001;
    nxt_seq = wrap ? seq_inc : seq_ff;
    finish  = 1'b0;
    run_lvl = level_ff;
    case (pat)
      toutu_pkg::PAT_NEG_PULSE:
      begin
        finish  = (el_step >= hi_ns);
        run_lvl = finish;
      end
      toutu_pkg::PAT_POS_PULSE:
      begin
        finish  = (el_step >= hi_ns);
        run_lvl = !finish;
      end
      toutu_pkg::PAT_PERIODIC:
      begin
        // zero count never matches, so the clock runs on
        finish  = wrap && cyc_cnt_ff != 16'h0000 &&
                  seq_inc == cyc_cnt_ff;
        run_lvl = !finish && (nxt_el < hi_ns);
      end
      toutu_pkg::PAT_SHIFT:
      begin
        // lsb first; counts above 16 repeat the pattern
        finish  = wrap && seq_inc == cyc_cnt_ff;
        run_lvl = !finish && bit_pat_ff[nxt_seq[3:0]];
      end
      default: ;
    endcase
  end

  // sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= toutu_pkg::S_IDLE;
    else if (!en_ff)
      state_ff <= toutu_pkg::S_IDLE;
    else
    begin
      case (state_ff)
        toutu_pkg::S_IDLE:  state_ff <= toutu_pkg::S_ARMED;
        toutu_pkg::S_ARMED:
          if (fire)
            state_ff <= bad_cfg ? toutu_pkg::S_HOLD : toutu_pkg::S_RUN;
        toutu_pkg::S_RUN:
          if (finish)
            state_ff <= casc ? toutu_pkg::S_ARMED
                             : toutu_pkg::S_HOLD;
        toutu_pkg::S_HOLD:  state_ff <= toutu_pkg::S_HOLD;
        default:            state_ff <= toutu_pkg::S_IDLE;
      endcase
    end
  end

  // working target: copied at enable, advanced per cascade pass
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wsec_ff <= 32'h00000000;
      wns_ff  <= 32'h00000000;
    end
    else if (state_ff == toutu_pkg::S_IDLE)
    begin
      wsec_ff <= {tgt_sec_hi_ff, tgt_sec_lo_ff};
      wns_ff  <= {tgt_ns_hi_ff, tgt_ns_lo_ff};
    end
    else if (state_ff == toutu_pkg::S_RUN && finish && casc)
    begin
      wsec_ff <= sum_sec;
      wns_ff  <= sum_ns;
    end
  end

  // elapsed time and cycle or shift count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      el_ff  <= 32'h00000000;
      seq_ff <= 16'h0000;
    end
    else if (fire)
    begin
      el_ff  <= 32'h00000000;
      seq_ff <= 16'h0000;
    end
    else if (state_ff == toutu_pkg::S_RUN)
    begin
      el_ff  <= nxt_el;
      seq_ff <= nxt_seq;
    end
  end

  // pin level and drive; a cascade unit lets go between passes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_ff <= 1'b0;
      drive_ff <= 1'b0;
    end
    else if (!en_ff)
      drive_ff <= 1'b0;
    else
    begin
      case (state_ff)
        toutu_pkg::S_IDLE:
          if (!casc)
          begin
            level_ff <= idle_lvl;
            drive_ff <= 1'b1;
          end
        toutu_pkg::S_ARMED:
          if (fire)
          begin
            level_ff <= bad_cfg ? level_ff : fire_lvl;
            drive_ff <= 1'b1;
          end
          else if (casc && early)
          begin
            level_ff <= idle_lvl;
            drive_ff <= 1'b1;
          end
        toutu_pkg::S_RUN:
        begin
          level_ff <= run_lvl;
          if (finish && casc)
            drive_ff <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // sticky done and error; hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_ff <= 1'b0;
      err_ff  <= 1'b0;
    end
    else
    begin
      if (state_ff == toutu_pkg::S_RUN && finish &&
          (!casc || cfg_one_ff[toutu_pkg::CFG_TAIL]))
        done_ff <= 1'b1;
      else if (wr_acc && pstrb[0] && paddr == toutu_pkg::OFS_STATUS &&
               pwdata[toutu_pkg::STS_DONE])
        done_ff <= 1'b0;
      if (fire && bad_cfg)
        err_ff <= 1'b1;
      else if (wr_acc && pstrb[0] && paddr == toutu_pkg::OFS_STATUS &&
               pwdata[toutu_pkg::STS_ERR])
        err_ff <= 1'b0;
    end
  end

  // notification gated by notify bit and enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= (done_ff || err_ff) && ie_ff &&
                cfg_one_ff[toutu_pkg::CFG_NOTIFY];
  end
  assign notify_irq = irq_ff;

  // optional extra stage delays the selected pin by one clock cycle
  // drive is delayed with the level, else a pass loses its last cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      late_ff     <= 1'b0;
      late_drv_ff <= 1'b0;
    end
    else
    begin
      late_ff     <= level_ff;
      late_drv_ff <= drive_ff;
    end
  end
  assign pin_lvl = edge_sel_ff[toutu_pkg::EDGE_SEL_BIT] ?
                   late_ff : level_ff;
  assign pin_drv = edge_sel_ff[toutu_pkg::EDGE_SEL_BIT] ?
                   late_drv_ff : drive_ff;

  toutu_pin_drive #(
    .NUM_PINS (NUM_PINS)
  ) u_pins (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_sel  (cfg_one_ff[toutu_pkg::CFG_PIN_LSB +: 4]),
    .level    (pin_lvl),
    .drive    (pin_drv),
    .gpio_out (gpio_out),
    .gpio_oe  (gpio_oe)
  );

  a_single_low_pre:
  assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == toutu_pkg::S_IDLE && en_ff && !casc &&
    pat == toutu_pkg::PAT_NEG_PULSE |=> level_ff && drive_ff)
    else $error("low pulse unit not high after enable");
  a_single_high_pre:
  assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == toutu_pkg::S_IDLE && en_ff && !casc &&
    pat == toutu_pkg::PAT_POS_PULSE |=> !level_ff && drive_ff)
    else $error("high pulse unit not low after enable");
  a_cascade_lead:
  assert property (@(posedge pclk) disable iff (!presetn)
    fire == 1'b0 && en_ff && casc && early &&
    state_ff == toutu_pkg::S_ARMED |=> level_ff == $past(idle_lvl))
    else $error("cascade preset level missing before trigger");
  a_neg_pulse_low:
  assert property (@(posedge pclk) disable iff (!presetn)
    fire && !bad_cfg && pat == toutu_pkg::PAT_NEG_PULSE
    |=> !level_ff ##1 (!level_ff || !en_ff ||
                       hi_ns <= toutu_pkg::CLK_PERIOD_NS))
    else $error("low pulse did not go low");
  a_pos_pulse_end:
  assert property (@(posedge pclk) disable iff (!presetn)
    en_ff && state_ff == toutu_pkg::S_RUN &&
    pat == toutu_pkg::PAT_POS_PULSE && el_step >= hi_ns
    |=> !level_ff && state_ff != toutu_pkg::S_RUN)
    else $error("high pulse not ended at width");
  a_fire_on_time:
  assert property (@(posedge pclk) disable iff (!presetn)
    en_ff && state_ff == toutu_pkg::S_ARMED && reached
    |=> state_ff != toutu_pkg::S_ARMED || !$past(en_ff))
    else $error("unit did not fire at target time");
  a_count_stop:
  assert property (@(posedge pclk) disable iff (!presetn)
    en_ff && state_ff == toutu_pkg::S_RUN && !casc &&
    pat == toutu_pkg::PAT_PERIODIC && finish
    |=> state_ff == toutu_pkg::S_HOLD && !level_ff)
    else $error("finite clock did not stop");
  a_notify_gate:
  assert property (@(posedge pclk) disable iff (!presetn)
    notify_irq |-> $past(ie_ff) &&
    $past(cfg_one_ff[toutu_pkg::CFG_NOTIFY]))
    else $error("notification without notify and enable");
endmodule // toutu_top
`default_nettype wire

// file: verification/test_timed_trigger_output_unit.sv
// self-checking bench of the timed output unit
`default_nettype none
module test_timed_trigger_output_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, meas_v = 1'b0, pready, pslverr, notify_irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, ptp_nsec = 32'h0, prdata, meas = 32'h0;
  logic [15:0] gpio_out, gpio_oe, pin_lvl;
  logic [3:0]  pin = 4'h0;
  logic [32:0] exp_q[$];
  int          mismatches = 0, checks = 0, seed = 32'h6a63;
  toutu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'h3), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ptp_sec(32'h0), .ptp_nsec(ptp_nsec), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .notify_irq(notify_irq));
  toutu_pin_model i_pins (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pin_lvl(pin_lvl));
  always #5 pclk = ~pclk;
  // precision time advances one clock period per cycle
  always @(posedge pclk) ptp_nsec <= ptp_nsec + 32'hA;
  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // compare each read or measurement with the oldest note
  always @(posedge pclk)
  begin
    if ((psel && penable && !pwrite && pready) || meas_v)
    begin
      checks++;
      if ((meas_v ? {1'b0, meas} : {pslverr, prdata}) !== exp_q.pop_front())
      begin
        mismatches++;
        $display("CHECK FAILED at %0t: result differs", $time);
      end
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic post(input logic [31:0] v, input logic [31:0] e);
    exp_q.push_back({1'b0, e});
    meas <= v;
    meas_v <= 1'b1;
    @(posedge pclk);
    meas_v <= 1'b0;
  endtask
  // count cycles the chosen pin is driven at one level
  task automatic count(input logic l, input int n, input logic [31:0] e);
    logic [31:0] c;
    c = 32'h0;
    repeat (n)
    begin
      @(posedge pclk);
      if (gpio_oe[pin] === 1'b1 && pin_lvl[pin] === l)
        c++;
    end
    post(c, e);
  endtask
  task automatic run(input logic [2:0] p, input logic [15:0] w,
                     input logic [15:0] per, input logic [15:0] cnt,
                     input logic now, input logic c);
    logic [31:0] t;
    apb(1'b1, 12'h030, 32'h0);
    pin = 4'($random(seed));
    // off the 10 ns grid, so a cascade unit gets its lead cycle
    t = ptp_nsec + (now ? 32'h000F4240 : 32'h000003ED);
    apb(1'b1, 12'h000, {20'h0, c, c, now, 2'h2, p, pin});
    apb(1'b1, 12'h004, {16'h0, w});
    apb(1'b1, 12'h008, {16'h0, per});
    apb(1'b1, 12'h010, {16'h0, cnt});
    apb(1'b1, 12'h014, 32'h0000000B);
    apb(1'b1, 12'h018, 32'h000000C8);
    apb(1'b1, 12'h020, {16'h0, t[15:0]});
    apb(1'b1, 12'h024, {16'h0, t[31:16]});
    apb(1'b1, 12'h030, 32'h1);
    // an immediate start fires at once, so its count must begin now
    repeat (now ? 0 : 5) @(posedge pclk);
  endtask
  task automatic irq(input logic [31:0] e);
    repeat (3) @(posedge pclk);
    post({31'h0, notify_irq}, e);
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h004, 33'h000000000);
    meas = 32'h0000FFFF & $random(seed);
    apb(1'b1, 12'h004, meas);
    rd(12'h004, {1'b0, meas});
    rd(12'h100, 33'h100000000);
    apb(1'b1, 12'h248, 32'h80);
    rd(12'h248, 33'h000000080);
    apb(1'b1, 12'h034, 32'h1);
    run(3'h2, 16'h4, 16'h0, 16'h0, 1'b0, 1'b0);
    count(1'b1, 3, 32'h3);
    count(1'b0, 150, 32'h4);
    irq(32'h1);
    apb(1'b1, 12'h034, 32'h0);
    irq(32'h0);
    apb(1'b1, 12'h038, 32'h3);
    apb(1'b1, 12'h034, 32'h1);
    irq(32'h0);
    run(3'h3, 16'h2, 16'h0, 16'h0, 1'b0, 1'b0);
    count(1'b0, 3, 32'h3);
    count(1'b1, 150, 32'h2);
    run(3'h3, 16'h2, 16'h0, 16'h0, 1'b1, 1'b0);
    count(1'b1, 150, 32'h2);
    run(3'h5, 16'h2, 16'h28, 16'h3, 1'b0, 1'b0);
    count(1'b1, 160, 32'h6);
    run(3'h6, 16'h0, 16'h14, 16'h4, 1'b0, 1'b0);
    count(1'b1, 160, 32'h6);
    // one-unit cascade chain: lead cycle, pulse, then again 200 ns on
    run(3'h2, 16'h2, 16'h0, 16'h0, 1'b0, 1'b1);
    count(1'b1, 80, 32'h1);
    count(1'b0, 20, 32'h2);
    tally_and_finish();
  end
  // watchdog, far beyond the thousand or so cycles the tests need
  initial
  begin
    #100us;
    mismatches++;
    tally_and_finish();
  end
endmodule // test_timed_trigger_output_unit
`default_nettype wire

// file: verification/toutu_pin_model.sv
// pin side model: pulled-down pins fed by the unit
`default_nettype none
module toutu_pin_model #(
  parameter int NUM_PINS = 16
) (
  // pins from the unit
  input  wire logic [NUM_PINS-1:0] gpio_out,
  input  wire logic [NUM_PINS-1:0] gpio_oe,
  // resolved wire levels
  output logic      [NUM_PINS-1:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // an undriven pin falls to its pull-down, never keeps a stale level
  assign pin_lvl = gpio_out & gpio_oe;
endmodule // toutu_pin_model
`default_nettype wire
